// ---- include/isp_pkg.sv ----
// Constants and types for the in-system programming sequencer
package isp_pkg;

  // --------------------------------------------------
  // Timing
  // --------------------------------------------------
  localparam int unsigned CLK_KHZ = 20000;
  localparam int unsigned ERASE_MS = 500;
  localparam int unsigned PROG_US = 75;
  localparam int unsigned CONFIG_US = 100;
  localparam int unsigned PROG_CYC = PROG_US * CLK_KHZ / 1000;
  localparam int unsigned CONFIG_CYC = CONFIG_US * CLK_KHZ / 1000;
  localparam int unsigned READ_CYC = 1;
  localparam int unsigned OTHER_CYC = 1;

  // --------------------------------------------------
  // Sizes
  // --------------------------------------------------
  localparam int unsigned N_PINS = 8;
  localparam int unsigned AW = 9;
  localparam int unsigned DW = 16;
  localparam int unsigned RDW = 32;
  localparam int unsigned CMDW = 33;
  localparam int unsigned UFM_WORDS = 512;
  localparam int unsigned SECTOR_WORDS = 256;
  localparam int unsigned SECTOR_BIT = 8;
  localparam int unsigned CFG_AW = 6;
  localparam int unsigned CFG_WORDS = 64;

  // --------------------------------------------------
  // Values
  // --------------------------------------------------
  localparam logic [DW-1:0] ERASED_WORD = 16'hFFFF;
  localparam logic [DW-1:0] ZERO_WORD = 16'h0000;
  localparam logic [RDW-1:0] ID_CODE = 32'h0F0F_1235; // Arbitrary value
  localparam logic CAP_MARK = 1'h1;

  // --------------------------------------------------
  // Operation codes
  // --------------------------------------------------
  localparam logic [7:0] OP_ENTER = 8'h01;
  localparam logic [7:0] OP_EXIT = 8'h02;
  localparam logic [7:0] OP_IDCODE = 8'h03;
  localparam logic [7:0] OP_ERASE_CFG = 8'h04;
  localparam logic [7:0] OP_ERASE_UFM = 8'h05;
  localparam logic [7:0] OP_PROG_CFG = 8'h06;
  localparam logic [7:0] OP_PROG_UFM = 8'h07;
  localparam logic [7:0] OP_READ_CFG = 8'h08;
  localparam logic [7:0] OP_READ_UFM = 8'h09;
  localparam logic [7:0] OP_CLAMP = 8'h0A;
  localparam logic [7:0] OP_BG_ENTER = 8'h0B;
  localparam logic [7:0] OP_RELOAD = 8'h0C;
  localparam logic [7:0] OP_SET_SECURE = 8'h0D;
  localparam logic [7:0] OP_SET_DONE = 8'h0E;

  // Per-pin clamp modes
  localparam logic [1:0] CLAMP_TRI = 2'h0;
  localparam logic [1:0] CLAMP_HOLD = 2'h1;
  localparam logic [1:0] CLAMP_HIGH = 2'h2;
  localparam logic [1:0] CLAMP_LOW = 2'h3;

  typedef struct packed {
    logic [7:0] op;
    logic [AW-1:0] addr;
    logic [DW-1:0] data;
  } isp_cmd_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h1,
    ST_PULSE = 2'h2
  } isp_state_t;

endpackage : isp_pkg

// ---- verilog/isp_flash_seq.sv ----
// In-system programming sequencer with flash arrays and pin control
`timescale 1ns/1ns
module isp_flash_seq
  import isp_pkg::*;
#(
  parameter int unsigned ERASE_CYC = ERASE_MS * CLK_KHZ
)
(
  // System clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // Test access link
  input wire logic TCK,
  input wire logic TMS,
  input wire logic TDI,
  output logic TDO,
  // User logic pin requests
  input wire logic [N_PINS-1:0] USER_OUT,
  input wire logic [N_PINS-1:0] USER_OE,
  // Pads
  output logic [N_PINS-1:0] PIN_OUT,
  output logic [N_PINS-1:0] PIN_OE,
  output logic [N_PINS-1:0] PIN_PULLUP,
  // User flash read from logic array
  input wire logic [AW-1:0] UFM_RADDR,
  output logic [DW-1:0] UFM_RDATA,
  // Status
  output logic PROG_MODE,
  output logic BUSY,
  output logic SECURE,
  output logic CFG_LOAD
);

  // --------------------------------------------------
  // Declarations
  // --------------------------------------------------
  logic [CMDW-1:0] sr_q;
  logic shifting_q;
  logic req_q;
  logic ack_s1_q;
  logic ack_s2_q;
  isp_cmd_t cmd_q;
  logic req_s1_q;
  logic req_s2_q;
  logic req_s3_q;
  logic ack_q;
  isp_state_t st_q;
  isp_state_t st_d;
  logic [31:0] cnt_q;
  logic [31:0] cnt_d;
  logic [31:0] pulse_len_q;
  logic ok_q;
  logic [RDW-1:0] rd_q;
  logic prog_q;
  logic bg_q;
  logic reload_q;
  logic boot_q;
  logic cfg_load_q;
  logic clamp_en_q;
  logic [2*N_PINS-1:0] clamp_q;
  logic [N_PINS-1:0] hold_out_q;
  logic [N_PINS-1:0] hold_oe_q;
  logic secure_q;
  logic done_q;
  logic [DW-1:0] cfg_q [CFG_WORDS];
  logic [DW-1:0] ufm_q [UFM_WORDS];
  logic [DW-1:0] ufm_rd_q;
  logic [N_PINS-1:0] pout_q;
  logic [N_PINS-1:0] poe_q;
  logic [N_PINS-1:0] ppu_q;
  logic [N_PINS-1:0] pout_d;
  logic [N_PINS-1:0] poe_d;
  logic [N_PINS-1:0] ppu_d;

  // --------------------------------------------------
  // Link side: shift, capture and update
  // --------------------------------------------------
  wire busy_t = req_q ^ ack_s2_q;
  wire upd = shifting_q & ~TMS & ~busy_t;
  wire [CMDW-1:0] capture = {CAP_MARK, rd_q};

  always_ff @(posedge TCK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      sr_q <= '0;
      shifting_q <= 1'b0;
    end
    else
    begin
      shifting_q <= TMS;
      if (TMS)
        sr_q <= {TDI, sr_q[CMDW-1:1]};
      else if (!shifting_q && !busy_t)
        sr_q <= capture;
    end
  end

  always_ff @(posedge TCK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      cmd_q <= '0;
      req_q <= 1'b0;
    end
    else if (upd)
    begin
      cmd_q <= isp_cmd_t'(sr_q);
      req_q <= ~req_q;
    end
  end

  // Completion back into the link domain
  always_ff @(posedge TCK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      ack_s1_q <= 1'b0;
      ack_s2_q <= 1'b0;
    end
    else
    begin
      ack_s1_q <= ack_q;
      ack_s2_q <= ack_s1_q;
    end
  end

  assign TDO = sr_q[0];

  // --------------------------------------------------
  // Request crossing into the system domain
  // --------------------------------------------------
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      req_s1_q <= 1'b0;
      req_s2_q <= 1'b0;
      req_s3_q <= 1'b0;
    end
    else
    begin
      req_s1_q <= req_q;
      req_s2_q <= req_s1_q;
      req_s3_q <= req_s2_q;
    end
  end

  wire start = req_s2_q ^ req_s3_q;

  // --------------------------------------------------
  // Command decode
  // --------------------------------------------------
  wire [7:0] op = cmd_q.op;
  wire op_enter = op == OP_ENTER;
  wire op_exit = op == OP_EXIT;
  wire op_id = op == OP_IDCODE;
  wire op_erase_cfg = op == OP_ERASE_CFG;
  wire op_erase_ufm = op == OP_ERASE_UFM;
  wire op_prog_cfg = op == OP_PROG_CFG;
  wire op_prog_ufm = op == OP_PROG_UFM;
  wire op_rd_cfg = op == OP_READ_CFG;
  wire op_rd_ufm = op == OP_READ_UFM;
  wire op_clamp = op == OP_CLAMP;
  wire op_bg = op == OP_BG_ENTER;
  wire op_set_sec = op == OP_SET_SECURE;
  wire op_set_done = op == OP_SET_DONE;
  wire in_isp = prog_q | bg_q;
  wire op_reload = (op == OP_RELOAD) & bg_q;
  wire op_erase = op_erase_cfg | op_erase_ufm;
  wire op_prog = op_prog_cfg | op_prog_ufm | op_set_sec | op_set_done;
  wire op_read = op_rd_cfg | op_rd_ufm;
  wire allowed = in_isp | op_enter | op_bg | op_clamp | op_id;
  wire [CFG_AW-1:0] cidx = cmd_q.addr[CFG_AW-1:0];
  wire [DW-1:0] cfg_word = cfg_q[cidx];
  wire [DW-1:0] ufm_word = ufm_q[cmd_q.addr];
  wire [DW-1:0] pdata = cmd_q.data;

  // Pulse length of the operation
  wire [31:0] dur_w = !allowed ? 32'(OTHER_CYC)
    : op_erase ? 32'(ERASE_CYC)
    : op_prog ? 32'(PROG_CYC)
    : op_reload ? 32'(CONFIG_CYC)
    : op_read ? 32'(READ_CYC)
    : 32'(OTHER_CYC);

  // --------------------------------------------------
  // Pulse sequencer
  // --------------------------------------------------
  wire fin = (st_q == ST_PULSE) && (cnt_q == 32'h0000_0000);
  wire act = fin & ok_q;

  always_comb
  begin
    st_d = st_q;
    cnt_d = cnt_q;
    unique case (st_q)
      ST_IDLE:
      begin
        cnt_d = dur_w - 32'h0000_0001;
        if (start)
          st_d = ST_PULSE;
      end
      ST_PULSE:
      begin
        cnt_d = cnt_q - 32'h0000_0001;
        if (fin)
          st_d = ST_IDLE;
      end
      default:
      begin
        st_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      st_q <= ST_IDLE;
      cnt_q <= '0;
      ok_q <= 1'b0;
      ack_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      if (st_q == ST_IDLE && start)
        ok_q <= allowed;
      if (fin)
        ack_q <= ~ack_q;
    end
  end

  // Pulse length measure
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
      pulse_len_q <= '0;
    else if (st_q == ST_IDLE)
      pulse_len_q <= '0;
    else
      pulse_len_q <= pulse_len_q + 32'h0000_0001;
  end

  // --------------------------------------------------
  // Modes and clamp settings
  // --------------------------------------------------
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      prog_q <= 1'b0;
      bg_q <= 1'b0;
      clamp_en_q <= 1'b0;
      clamp_q <= '0;
      hold_out_q <= '0;
      hold_oe_q <= '0;
    end
    else if (act)
    begin
      if (op_enter)
      begin
        prog_q <= 1'b1;
        hold_out_q <= USER_OUT;
        hold_oe_q <= USER_OE;
      end
      if (op_bg)
        bg_q <= 1'b1;
      if (op_clamp)
      begin
        clamp_en_q <= 1'b1;
        clamp_q <= pdata;
      end
      if (op_exit || op_reload)
      begin
        prog_q <= 1'b0;
        bg_q <= 1'b0;
        clamp_en_q <= 1'b0;
      end
    end
  end

  // Reload hold and configuration load pulse
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      reload_q <= 1'b0;
      boot_q <= 1'b1;
      cfg_load_q <= 1'b0;
    end
    else
    begin
      boot_q <= 1'b0;
      if (st_q == ST_IDLE && start && op_reload)
        reload_q <= 1'b1;
      else if (fin)
        reload_q <= 1'b0;
      cfg_load_q <= boot_q | (act & op_reload);
    end
  end

  // --------------------------------------------------
  // Flash arrays and protection bits
  // --------------------------------------------------
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      secure_q <= 1'b0;
      done_q <= 1'b0;
    end
    else if (act && op_erase_cfg)
    begin
      secure_q <= 1'b0;
      done_q <= 1'b0;
    end
    else if (act)
    begin
      if (op_set_sec)
        secure_q <= 1'b1;
      if (op_set_done)
        done_q <= 1'b1;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (act && op_erase_cfg)
      for (int i = 0; i < CFG_WORDS; i++)
        cfg_q[i] <= ERASED_WORD;
    else if (act && op_prog_cfg)
      cfg_q[cidx] <= cfg_word & pdata;
  end

  always_ff @(posedge CLK)
  begin
    if (act && op_erase_ufm)
    begin
      for (int i = 0; i < UFM_WORDS; i++)
        if (i / SECTOR_WORDS == int'(cmd_q.addr[SECTOR_BIT]))
          ufm_q[i] <= ERASED_WORD;
    end
    else if (act && op_prog_ufm)
      ufm_q[cmd_q.addr] <= ufm_word & pdata;
  end

  // Read results
  wire [RDW-1:0] rd_d = op_id ? ID_CODE
    : op_rd_cfg ? {ZERO_WORD, secure_q ? ZERO_WORD : cfg_word}
    : {ZERO_WORD, ufm_word};

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
      rd_q <= '0;
    else if (act && (op_id || op_read))
      rd_q <= rd_d;
  end

  // Logic-array read port
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
      ufm_rd_q <= '0;
    else
      ufm_rd_q <= ufm_q[UFM_RADDR];
  end

  // --------------------------------------------------
  // Pin control
  // --------------------------------------------------
  wire iso = ~done_q | reload_q | (prog_q & ~clamp_en_q);
  wire clamp = prog_q & clamp_en_q;

  for (genvar g = 0; g < N_PINS; g++)
  begin : g_pin
    wire [1:0] m = clamp_q[2*g +: 2];
    wire hold = m == CLAMP_HOLD;
    wire c_out = hold ? hold_out_q[g] : (m == CLAMP_HIGH);
    wire c_oe = hold ? hold_oe_q[g] : (m == CLAMP_HIGH) | (m == CLAMP_LOW);
    assign pout_d[g] = iso ? 1'b0 : clamp ? c_out : USER_OUT[g];
    assign poe_d[g] = iso ? 1'b0 : clamp ? c_oe : USER_OE[g];
    assign ppu_d[g] = iso | (clamp & ~c_oe);
  end

  // Single registered switch keeps transitions clean
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      pout_q <= '0;
      poe_q <= '0;
      ppu_q <= '1;
    end
    else
    begin
      pout_q <= pout_d;
      poe_q <= poe_d;
      ppu_q <= ppu_d;
    end
  end

  // --------------------------------------------------
  // Outputs
  // --------------------------------------------------
  assign PIN_OUT = pout_q;
  assign PIN_OE = poe_q;
  assign PIN_PULLUP = ppu_q;
  assign UFM_RDATA = ufm_rd_q;
  assign PROG_MODE = in_isp;
  assign BUSY = st_q != ST_IDLE;
  assign SECURE = secure_q;
  assign CFG_LOAD = cfg_load_q;

  // --------------------------------------------------
  // Assertions
  // --------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  sequence s_reload_go;
    (st_q == ST_IDLE) && start && op_reload;
  endsequence

  sequence s_tri_hold;
    (PIN_OE == '0 && PIN_PULLUP == '1)[*3];
  endsequence

  reload_tri_a: assert property (s_reload_go |=> ##1 s_tri_hold)
    else $error("pins not tri-stated during reload");
  prog_time_a: assert property (act && op_prog |-> pulse_len_q == 32'(PROG_CYC - 1))
    else $error("program pulse length wrong");
  erase_time_a: assert property (act && op_erase |-> pulse_len_q == 32'(ERASE_CYC - 1))
    else $error("erase pulse length wrong");
  read_pulse_a: assert property ((st_q == ST_IDLE) && start && allowed && op_read |=> fin)
    else $error("read pulse not one cycle");
  secure_read_a: assert property (act && op_rd_cfg && secure_q |=> rd_q == '0)
    else $error("protected array returned data");
  ufm_read_a: assert property (act && op_rd_ufm |=> rd_q == {ZERO_WORD, $past(ufm_word)})
    else $error("user flash read wrong");
  erase_clear_a: assert property (act && op_erase_cfg |=> !secure_q && !done_q)
    else $error("erase left protection bits");
  done_gate_a: assert property (!done_q && !$past(done_q) |-> PIN_OE == '0)
    else $error("pin driven before completion");
  enter_pins_a: assert property (prog_q && !clamp_en_q |=> PIN_OE == '0 && PIN_PULLUP == '1)
    else $error("pins not isolated in programming");
  bg_pins_a: assert property (bg_q && !prog_q && !reload_q && done_q |=> PIN_OE == $past(USER_OE))
    else $error("background update disturbed pins");
  cfg_keep_a: assert property (act && op_prog_ufm |=> $stable(cfg_word))
    else $error("user flash write altered configuration");

endmodule : isp_flash_seq

// ---- sim/isp_prog_model.sv ----
// Programmer model on the far side of the test access link
`timescale 1ns/1ns
module isp_prog_model
  import isp_pkg::*;
(
  // Link to the device
  output logic TCK,
  output logic TMS,
  output logic TDI,
  input wire logic TDO
);
  // --------------------------------------------------
  // Clocking and framing
  // --------------------------------------------------
  initial
  begin
    TCK = 1'b0;
    TMS = 1'b0;
    TDI = 1'b0;
  end

  // Idle edges, clock stands still afterwards
  task automatic run(input int n);
    repeat (n)
    begin
      #7 TCK = 1'b1;
      #8 TCK = 1'b0;
    end
  endtask : run

  // Shift a frame LSB first while capturing, then update and idle
  task automatic xfer(input logic [CMDW-1:0] cmd, input int n, output logic [CMDW-1:0] got);
    TMS = 1'b1;
    for (int i = 0; i < CMDW; i++)
    begin
      TDI = cmd[i];
      got[i] = TDO;
      run(1);
    end
    TMS = 1'b0;
    TDI = ~TDI;
    run(n);
  endtask : xfer
endmodule : isp_prog_model

// ---- sim/tb_top.sv ----
// Self-checking bench for the programming sequencer
`timescale 1ns/1ns
module tb_top
  import isp_pkg::*;
;
  // --------------------------------------------------
  // Signals and helpers
  // --------------------------------------------------
  localparam int EC = 50;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic tck, tms, tdi, tdo;
  logic [7:0] u_out = 8'h00;
  logic [7:0] u_oe = 8'h00;
  logic [7:0] p_out, p_oe, p_pu;
  logic [8:0] raddr = 9'h000;
  logic [15:0] rdata;
  logic pmode, busy, secure, cload;
  int error_cnt = 0;
  int n_tests = 0;
  int blen = 0;
  int bcnt, loads;
  logic [32:0] got;
  logic [15:0] ufm_m [512];
  logic [15:0] cfg_m [64];
  logic sec_m = 1'b0;
  logic [16:0] q[$];

  always #25 clk = ~clk;

  isp_flash_seq #(.ERASE_CYC(EC)) u_dut (.CLK(clk), .RST_N(rst_n), .TCK(tck), .TMS(tms), .TDI(tdi), .TDO(tdo),
    .USER_OUT(u_out), .USER_OE(u_oe), .PIN_OUT(p_out), .PIN_OE(p_oe), .PIN_PULLUP(p_pu), .UFM_RADDR(raddr),
    .UFM_RDATA(rdata), .PROG_MODE(pmode), .BUSY(busy), .SECURE(secure), .CFG_LOAD(cload));
  isp_prog_model u_prog (.TCK(tck), .TMS(tms), .TDI(tdi), .TDO(tdo));

  // Busy length and image load count
  always @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      bcnt <= 0;
      loads <= 0;
    end
    else
    begin
      bcnt <= (busy === 1'b1) ? bcnt + 1 : 0;
      if (busy !== 1'b1 && bcnt != 0)
        blen <= bcnt;
      if (cload === 1'b1)
        loads <= loads + 1;
    end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish

  function automatic int idle_for(input logic [7:0] o);
    int c;
    c = (o == OP_ERASE_CFG || o == OP_ERASE_UFM) ? EC
      : (o == OP_PROG_CFG || o == OP_PROG_UFM || o == OP_SET_SECURE || o == OP_SET_DONE) ? PROG_CYC
      : (o == OP_RELOAD) ? CONFIG_CYC : 1;
    return c * 50 / 15 + 30;
  endfunction : idle_for

  function automatic logic [15:0] clamp_exp(input logic [15:0] m, input logic [7:0] so, input logic [7:0] se);
    logic [7:0] oe, out;
    for (int g = 0; g < 8; g++)
    begin
      oe[g] = m[2*g+:2] == CLAMP_HIGH || m[2*g+:2] == CLAMP_LOW || (m[2*g+:2] == CLAMP_HOLD && se[g]);
      out[g] = m[2*g+:2] == CLAMP_HIGH || (m[2*g+:2] == CLAMP_HOLD && so[g]);
    end
    return {oe, out};
  endfunction : clamp_exp

  task automatic op(input logic [7:0] o, input logic [8:0] a, input logic [15:0] d);
    u_prog.xfer({o, a, d}, idle_for(o), got);
    @(negedge clk);
  endtask : op

  task automatic act(input logic [7:0] o, input logic [8:0] a, input logic [15:0] d);
    op(o, a, d);
    if (o == OP_ERASE_CFG)
    begin
      foreach (cfg_m[i])
        cfg_m[i] = ERASED_WORD;
      sec_m = 1'b0;
    end
    if (o == OP_ERASE_UFM)
      for (int i = 0; i < SECTOR_WORDS; i++)
        ufm_m[{a[8], 8'(i)}] = ERASED_WORD;
    if (o == OP_PROG_CFG)
      cfg_m[a[5:0]] &= d;
    if (o == OP_PROG_UFM)
      ufm_m[a] &= d;
    if (o == OP_SET_SECURE)
      sec_m = 1'b1;
  endtask : act

  task automatic vfy(input logic [7:0] o, input logic [8:0] a);
    logic [15:0] e;
    e = (o == OP_READ_UFM) ? ufm_m[a] : sec_m ? ZERO_WORD : cfg_m[a[5:0]];
    op(o, a, 16'h0000);
    op(OP_IDCODE, 9'h000, 16'h0000);
    chk("capture_mark", 32'(got[32]), 32'(CAP_MARK));
    chk("read_word", got[31:0], {16'h0000, e});
  endtask : vfy

  task automatic vall();
    foreach (q[i])
      vfy(q[i][16:9], q[i][8:0]);
  endtask : vall

  task automatic pins(input logic [7:0] oe, input logic [7:0] out, input logic [7:0] pu);
    chk("pin_oe", 32'(p_oe), 32'(oe));
    chk("pin_out", 32'(p_out & oe), 32'(out & oe));
    chk("pin_pullup", 32'(p_pu & pu), 32'(pu));
  endtask : pins

  task automatic user();
    u_out = 8'($urandom);
    u_oe = 8'($urandom);
    repeat (4) @(negedge clk);
  endtask : user

  task automatic id_check();
    op(OP_IDCODE, 9'h000, 16'h0000);
    op(OP_IDCODE, 9'h000, 16'h0000);
    chk("id", got[31:0], ID_CODE);
  endtask : id_check

  // --------------------------------------------------
  // Tests
  // --------------------------------------------------
  initial
  begin
    logic [8:0] a;
    logic [7:0] o, so, se;
    logic [15:0] m, ce;
    void'($urandom(32'h25041e65));
    u_prog.run(3);
    pins(8'h00, 8'h00, 8'hFF);
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    user();
    pins(8'h00, 8'h00, 8'h00);
    chk("loads", loads, 1);
    op(OP_ENTER, 9'h000, 16'h0000);
    chk("prog_mode", 32'(pmode), 1);
    user();
    pins(8'h00, 8'h00, 8'hFF);
    id_check();
    $display("test enter done");
    act(OP_ERASE_CFG, 9'h000, 16'h0000);
    chk("erase_len", 32'(blen >= EC && blen <= EC + 2), 1);
    act(OP_ERASE_UFM, 9'h000, 16'h0000);
    act(OP_ERASE_UFM, 9'h100, 16'h0000);
    for (int k = 0; k < 6; k++)
    begin
      o = k[0] ? OP_PROG_UFM : OP_PROG_CFG;
      a = {k[1], 8'($urandom)};
      act(o, a, 16'($urandom));
      chk("prog_len", 32'(blen >= PROG_CYC && blen <= PROG_CYC + 2), 1);
      act(o, a, 16'($urandom));
      q.push_back({k[0] ? OP_READ_UFM : OP_READ_CFG, a});
      vfy(q[k][16:9], a);
      raddr = a;
      repeat (2) @(negedge clk);
      if (k[0])
        chk("array_read", 32'(rdata), 32'(ufm_m[a]));
    end
    $display("test program done");
    act(OP_ERASE_UFM, 9'h100, 16'h0000);
    vall();
    act(OP_SET_SECURE, 9'h000, 16'h0000);
    act(OP_ERASE_UFM, 9'h000, 16'h0000);
    chk("secure", 32'(secure), 1);
    vall();
    act(OP_ERASE_CFG, 9'h000, 16'h0000);
    chk("secure", 32'(secure), 0);
    vall();
    $display("test secure done");
    act(OP_SET_DONE, 9'h000, 16'h0000);
    op(OP_EXIT, 9'h000, 16'h0000);
    chk("prog_mode", 32'(pmode), 0);
    user();
    pins(u_oe, u_out, 8'h00);
    op(OP_PROG_UFM, q[1][8:0], 16'h0000);
    $display("test exit done");
    so = 8'($urandom);
    se = 8'($urandom) | 8'h02;
    u_out = so;
    u_oe = se;
    repeat (3) @(negedge clk);
    op(OP_ENTER, 9'h000, 16'h0000);
    id_check();
    m = {8'($urandom), 8'hE4};
    op(OP_CLAMP, 9'h000, m);
    user();
    ce = clamp_exp(m, so, se);
    pins(ce[15:8], ce[7:0], 8'h00);
    vall();
    op(OP_EXIT, 9'h000, 16'h0000);
    user();
    pins(u_oe, u_out, 8'h00);
    $display("test clamp done");
    op(OP_BG_ENTER, 9'h000, 16'h0000);
    chk("prog_mode", 32'(pmode), 1);
    user();
    pins(u_oe, u_out, 8'h00);
    act(OP_PROG_CFG, q[0][8:0], 16'($urandom));
    vfy(OP_READ_CFG, q[0][8:0]);
    fork
      op(OP_RELOAD, 9'h000, 16'h0000);
      begin
        repeat (200) @(negedge clk);
        pins(8'h00, 8'h00, 8'hFF);
      end
    join
    chk("loads", loads, 2);
    user();
    pins(u_oe, u_out, 8'h00);
    $display("test background done");
    tally_and_finish();
  end

  initial
  begin
    #4000000;
    error_cnt++;
    $display("Error watchdog expired");
    tally_and_finish();
  end
endmodule : tb_top
